// >>> include/cbt_defs.vh
// Purpose: constants for the CAN bit timing / message object block
// Assumes: APB byte addresses, 8-bit registers in low bits of a word
// Notes:   printed offsets are not multiples of four, so they are indices
`ifndef CBT_DEFS_VH
`define CBT_DEFS_VH
// register indices (byte address = index * 4)
`define CBT_IDX_PAGE      8'hb1
`define CBT_IDX_OBJECT_CONFIG     8'hb3
`define CBT_IDX_IDT_HI    8'hbc
`define CBT_IDX_IDT_LO    8'hbd
`define CBT_IDX_DATA      8'hb2
`define CBT_IDX_GCON      8'h80
`define CBT_IDX_BT1       8'h81
`define CBT_IDX_BT2       8'h82
`define CBT_IDX_BT3       8'h83
`define CBT_IDX_TIM_LO    8'h84
`define CBT_IDX_TIM_HI    8'h85
`define CBT_IDX_TTC_LO    8'h86
`define CBT_IDX_TTC_HI    8'h87
`define CBT_IDX_STMP_LO   8'h88
`define CBT_IDX_STMP_HI   8'h89
`define CBT_IDX_STAT      8'h8a
`define CBT_IDX_TEC       8'h8b
`define CBT_IDX_REC       8'h8c
`define CBT_IDX_OBJEN     8'h8d
`define CBT_IDX_OSTAT     8'h8e
// general control bits
`define CBT_GCON_ENA      1
`define CBT_GCON_TTC      5
`define CBT_GCON_SYNC     4
`define CBT_GCON_TIMER_OVERRUN_IRQ_ENABLE     7
// page fields
`define CBT_PG_SEL_HI     5
`define CBT_PG_SEL_LO     4
`define CBT_PG_HOLD       3
// object status bits
`define CBT_OST_TRANSMIT_OK_FLAG      6
`define CBT_OST_RECEIVE_OK_FLAG      5
`define CBT_OST_DLCW      7
// confinement thresholds
`define CBT_ERR_PASSIVE   9'h0080
`define CBT_ERR_BUSOFF    9'h0100
`define CBT_ST_ACTIVE     2'h0
`define CBT_ST_PASSIVE    2'h1
`define CBT_ST_BUSOFF     2'h2
// object configuration codes
`define CBT_CFG_OFF       2'h0
`define CBT_CFG_TX        2'h1
`define CBT_CFG_RX        2'h2
`define CBT_CFG_RXBUF     2'h3
`define CBT_DLC_MAX       4'h8
`define CBT_TIMER_MAX     16'hffff
`define CBT_TIMER_ZERO    16'h0000
`define CBT_SUSPEND_BITS  4'h8
`endif

// >>> src/cbt_core.v
// Purpose: bit timing, fault confinement, timer and message object page
// Assumes: frame engine outside supplies frame events and error events
`timescale 1ns/1ns
`include "cbt_defs.vh"
module cbt_core (
  // clock and reset
  input  wire        clk,
  input  wire        rst_b,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  // can bus pins
  input  wire        can_rx,
  output wire        can_tx,
  output wire        can_tx_oe,
  // frame engine events
  input  wire        frame_sof,
  input  wire        frame_eof,
  input  wire        rx_ok,
  input  wire        tx_ok,
  input  wire [1:0]  ev_obj,
  input  wire [3:0]  rx_dlc,
  input  wire        remote_rx,
  input  wire        tx_err,
  input  wire        rx_err,
  input  wire        tx_bit,
  input  wire        err_frame_req,
  // status to frame engine
  output reg         sample_point,
  output reg         sampled_bit,
  output wire        send_active_err,
  output wire        retransmit_ok,
  output wire        tx_allowed,
  output wire        reply_go,
  output reg         timer_overrun
);
  // registers
  reg  [7:0]  gcon;
  reg  [5:0]  quantum_prescaler;
  reg  [2:0]  propagation_segment_len;
  reg  [2:0]  phase_one_len;
  reg  [2:0]  phase_two_len;
  reg  [1:0]  jump_width;
  reg  [1:0]  object_select;
  reg         index_hold_n;
  reg  [2:0]  data_byte_index;
  reg  [7:0]  object_config   [0:3];
  reg  [7:0]  idt_hi  [0:3];
  reg  [7:0]  idt_lo  [0:3];
  reg  [7:0]  ostat   [0:3];
  reg  [15:0] stamp   [0:3];
  reg  [7:0]  data_mem [0:31];
  reg  [3:0]  object_enable_reg;
  reg  [8:0]  transmit_error_counter;
  reg  [8:0]  receive_error_counter;
  reg  [15:0] can_timer;
  reg  [15:0] trigger_capture;
  reg  [5:0]  tq_cnt;
  reg  [3:0]  seg_cnt;
  reg  [1:0]  seg;
  reg  [3:0]  seg_end;
  reg         rx_prev;
  reg  [3:0]  suspend_cnt;
  wire        wr_en;
  wire        rd_en;
  wire [7:0]  idx;
  wire        tq_tick;
  wire [1:0]  conf_state;
  wire [4:0]  data_addr;
  integer     i;

  localparam SEG_SYNC = 2'd0;
  localparam SEG_PROP = 2'd1;
  localparam SEG_PH1  = 2'd2;
  localparam SEG_PH2  = 2'd3;

  // a field plus one, used for the prop, phase and jump width lengths (sync is fixed at 1)
  function [3:0] cbt_len;
    input [2:0] f;
    begin
      cbt_len = {1'b0, f} + 4'h1;
    end
  endfunction

  // zero-wait apb: access phase completes in one cycle
  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  assign wr_en   = psel & penable & pwrite;
  assign rd_en   = psel & ~penable & ~pwrite;
  assign idx     = paddr[9:2];
  assign data_addr = {object_select, data_byte_index};

  assign conf_state = (transmit_error_counter >= `CBT_ERR_BUSOFF) ? `CBT_ST_BUSOFF :
                      ((transmit_error_counter >= `CBT_ERR_PASSIVE) ||
                       (receive_error_counter >= `CBT_ERR_PASSIVE)) ? `CBT_ST_PASSIVE :
                      `CBT_ST_ACTIVE;
  // active error frames only when active
  assign send_active_err = err_frame_req & (conf_state == `CBT_ST_ACTIVE);
  assign can_tx_oe = gcon[`CBT_GCON_ENA] & (conf_state != `CBT_ST_BUSOFF) & ~tx_bit;
  assign can_tx    = 1'b0;
  assign tx_allowed = (conf_state != `CBT_ST_BUSOFF) && (suspend_cnt == 4'h0);
  assign retransmit_ok = ~gcon[`CBT_GCON_TTC];
  assign reply_go = remote_rx & object_config[ev_obj][5] & object_enable_reg[ev_obj];

  assign tq_tick = (tq_cnt == quantum_prescaler);

  // bit timing: segments, sample point and resync
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tq_cnt       <= 6'h00;
      seg_cnt      <= 4'h0;
      seg          <= SEG_SYNC;
      seg_end      <= 4'h1;
      rx_prev      <= 1'b1;
      sample_point <= 1'b0;
      sampled_bit  <= 1'b1;
    end else begin
      sample_point <= 1'b0;
      rx_prev      <= can_rx;
      if (!gcon[`CBT_GCON_ENA]) begin
        tq_cnt  <= 6'h00;
        seg_cnt <= 4'h0;
        seg     <= SEG_SYNC;
        seg_end <= 4'h1;
      end else if (rx_prev & ~can_rx & (seg == SEG_PH2)) begin
        if ({2'b00, cbt_len({1'b0, jump_width})} >= seg_end - seg_cnt) begin
          tq_cnt <= 6'h00; seg <= SEG_PROP; seg_cnt <= 4'h0;
          seg_end <= cbt_len(propagation_segment_len);
        end else
          seg_end <= seg_end - cbt_len({1'b0, jump_width});
      end else if (rx_prev & ~can_rx & (seg == SEG_PH1)) begin
        seg_end <= seg_end + cbt_len({1'b0, jump_width});
        tq_cnt  <= 6'h00;
      end else if (tq_tick) begin
        tq_cnt <= 6'h00;
        if (seg_cnt + 4'h1 >= seg_end) begin
          seg_cnt <= 4'h0;
          case (seg)
            SEG_SYNC: begin seg <= SEG_PROP; seg_end <= cbt_len(propagation_segment_len); end
            SEG_PROP: begin seg <= SEG_PH1; seg_end <= cbt_len(phase_one_len); end
            SEG_PH1: begin
              seg <= SEG_PH2;
              seg_end <= cbt_len(phase_two_len);
              sample_point <= 1'b1;
              sampled_bit  <= can_rx;
            end
            SEG_PH2: begin seg <= SEG_SYNC; seg_end <= 4'h1; end
            default: begin seg <= SEG_SYNC; seg_end <= 4'h1; end
          endcase
        end else
          seg_cnt <= seg_cnt + 4'h1;
      end else
        tq_cnt <= tq_cnt + 6'h01;
    end
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      can_timer       <= `CBT_TIMER_ZERO;
      trigger_capture <= `CBT_TIMER_ZERO;
      timer_overrun   <= 1'b0;
    end else begin
      timer_overrun <= 1'b0;
      if (gcon[`CBT_GCON_ENA] & tq_tick) begin
        can_timer <= can_timer + 16'h0001;
        if (can_timer == `CBT_TIMER_MAX)
          timer_overrun <= gcon[`CBT_GCON_TIMER_OVERRUN_IRQ_ENABLE];
      end
      if (gcon[`CBT_GCON_TTC] &&
          (gcon[`CBT_GCON_SYNC] ? frame_eof : frame_sof))
        trigger_capture <= can_timer;
    end
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      transmit_error_counter <= 9'h000;
      receive_error_counter  <= 9'h000;
      suspend_cnt            <= 4'h0;
    end else begin
      if (tx_err && transmit_error_counter < `CBT_ERR_BUSOFF)
        transmit_error_counter <= transmit_error_counter + 9'h008;
      else if (tx_ok && transmit_error_counter != 9'h000)
        transmit_error_counter <= transmit_error_counter - 9'h001;
      if (rx_err && receive_error_counter < `CBT_ERR_BUSOFF)
        receive_error_counter <= receive_error_counter + 9'h001;
      else if (rx_ok && receive_error_counter != 9'h000)
        receive_error_counter <= receive_error_counter - 9'h001;
      if (tx_ok && conf_state == `CBT_ST_PASSIVE)
        suspend_cnt <= `CBT_SUSPEND_BITS;
      else if (sample_point && suspend_cnt != 4'h0)
        suspend_cnt <= suspend_cnt - 4'h1;
    end
  end

  // register writes and object updates; hardware events win over writes
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      gcon <= 8'h00;
      quantum_prescaler <= 6'h00;
      propagation_segment_len <= 3'h0;
      phase_one_len <= 3'h0;
      phase_two_len <= 3'h0;
      jump_width <= 2'h0;
      object_select <= 2'h0;
      index_hold_n <= 1'b0;
      data_byte_index <= 3'h0;
      object_enable_reg <= 4'h0;
      for (i = 0; i < 4; i = i + 1) begin
        object_config[i] <= 8'h00; idt_hi[i] <= 8'h00; idt_lo[i] <= 8'h00;
        ostat[i] <= 8'h00; stamp[i] <= 16'h0000;
      end
      for (i = 0; i < 32; i = i + 1)
        data_mem[i] <= 8'h00;
    end else begin
      if (wr_en) begin
        case (idx)
          `CBT_IDX_GCON: gcon <= pwdata[7:0];
          `CBT_IDX_BT1: quantum_prescaler <= pwdata[5:0];
          `CBT_IDX_BT2: begin propagation_segment_len <= pwdata[2:0];
                              jump_width <= pwdata[5:4]; end
          `CBT_IDX_BT3: begin phase_one_len <= pwdata[2:0];
                              phase_two_len <= pwdata[6:4]; end
          `CBT_IDX_PAGE: begin
            object_select   <= pwdata[`CBT_PG_SEL_HI:`CBT_PG_SEL_LO];
            index_hold_n    <= pwdata[`CBT_PG_HOLD];
            data_byte_index <= pwdata[2:0];
          end
          `CBT_IDX_OBJECT_CONFIG: begin
            object_config[object_select] <= pwdata[7:0];
            object_enable_reg[object_select] <= (pwdata[7:6] != `CBT_CFG_OFF);
          end
          `CBT_IDX_IDT_HI: idt_hi[object_select] <= pwdata[7:0];
          `CBT_IDX_IDT_LO: idt_lo[object_select] <= {pwdata[7:5], 5'h00};
          `CBT_IDX_DATA: data_mem[data_addr] <= pwdata[7:0];
          `CBT_IDX_OSTAT: ostat[object_select] <= ostat[object_select] & pwdata[7:0];
          default: ;
        endcase
      end
      if ((wr_en | (psel & penable & ~pwrite)) && idx == `CBT_IDX_DATA && !index_hold_n)
        data_byte_index <= data_byte_index + 3'h1;
      if (rx_ok) begin
        stamp[ev_obj] <= can_timer;
        ostat[ev_obj][`CBT_OST_RECEIVE_OK_FLAG] <= 1'b1;
        object_config[ev_obj][3:0] <= (rx_dlc > `CBT_DLC_MAX) ? `CBT_DLC_MAX : rx_dlc;
        if (rx_dlc != object_config[ev_obj][3:0])
          ostat[ev_obj][`CBT_OST_DLCW] <= 1'b1;
      end
      if (tx_ok) begin
        stamp[ev_obj] <= can_timer;
        ostat[ev_obj][`CBT_OST_TRANSMIT_OK_FLAG] <= 1'b1;
        object_enable_reg[ev_obj] <= 1'b0;
      end
    end
  end

  // read mux, registered in the setup cycle
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b)
      prdata <= 32'h0000_0000;
    else if (rd_en) begin
      case (idx)
        `CBT_IDX_GCON:    prdata <= {24'h00_0000, gcon};
        `CBT_IDX_BT1:     prdata <= {26'h000_0000, quantum_prescaler};
        `CBT_IDX_BT2:     prdata <= {26'h000_0000, jump_width, 1'b0, propagation_segment_len};
        `CBT_IDX_BT3:     prdata <= {25'h000_0000, phase_two_len, 1'b0, phase_one_len};
        `CBT_IDX_PAGE:    prdata <= {26'h000_0000, object_select, index_hold_n,
                                     data_byte_index};
        `CBT_IDX_OBJECT_CONFIG:   prdata <= {24'h00_0000, object_config[object_select]};
        `CBT_IDX_IDT_HI:  prdata <= {24'h00_0000, idt_hi[object_select]};
        `CBT_IDX_IDT_LO:  prdata <= {24'h00_0000, idt_lo[object_select]};
        `CBT_IDX_DATA:    prdata <= {24'h00_0000, data_mem[data_addr]};
        `CBT_IDX_TIM_LO:  prdata <= {24'h00_0000, can_timer[7:0]};
        `CBT_IDX_TIM_HI:  prdata <= {24'h00_0000, can_timer[15:8]};
        `CBT_IDX_TTC_LO:  prdata <= {24'h00_0000, trigger_capture[7:0]};
        `CBT_IDX_TTC_HI:  prdata <= {24'h00_0000, trigger_capture[15:8]};
        `CBT_IDX_STMP_LO: prdata <= {24'h00_0000, stamp[object_select][7:0]};
        `CBT_IDX_STMP_HI: prdata <= {24'h00_0000, stamp[object_select][15:8]};
        `CBT_IDX_STAT:    prdata <= {30'h0000_0000, conf_state};
        `CBT_IDX_TEC:     prdata <= {23'h00_0000, transmit_error_counter};
        `CBT_IDX_REC:     prdata <= {23'h00_0000, receive_error_counter};
        `CBT_IDX_OBJEN:   prdata <= {28'h000_0000, object_enable_reg};
        `CBT_IDX_OSTAT:   prdata <= {24'h00_0000, ostat[object_select]};
        default:          prdata <= 32'h0000_0000;
      endcase
    end
  end
endmodule // cbt_core

// >>> dv/cbt_checker.sv
// Purpose: port-level checks of cbt_core
// Assumes: registers change only through completed apb writes
// Notes:   shadows of written fields let the checks see the programming
`timescale 1ns/1ns
module cbt_checker (
  // clock and reset
  input wire        clk,
  input wire        rst_b,
  // apb
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  // bus and events
  input wire        can_rx,
  input wire        can_tx_oe,
  input wire        tx_err,
  input wire        remote_rx,
  input wire [1:0]  ev_obj,
  // status
  input wire        sample_point,
  input wire        retransmit_ok,
  input wire        reply_go,
  input wire        timer_overrun
);
  wire        wr  = psel & penable & pwrite;
  wire [9:0]  idx = paddr[11:2];
  reg  [7:0]  gcon, bt1, bt2, bt3;
  reg  [3:0]  reply_valid;
  reg  [1:0]  sel;
  reg         off_seen, txe_seen, sp_ok, ovf_ok;
  reg  [11:0] sp_cnt;
  reg  [23:0] ovf_cnt;
  wire [6:0]  q       = {1'b0, bt1[5:0]} + 7'h01;
  // bit time and timer wrap time, both in clocks
  wire [11:0] sp_len  = (12'h004 + bt2[2:0] + bt3[2:0] + bt3[6:4]) * q;
  wire [23:0] ovf_len = {1'b0, q, 16'h0000};
  // shadows and interval counters; bus activity or retiming voids a period check
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      {gcon, bt1, bt2, bt3} <= 32'h0000_0000;
      {reply_valid, sel, off_seen, txe_seen, sp_ok, ovf_ok} <= 10'h000;
      sp_cnt  <= 12'h000;
      ovf_cnt <= 24'h00_0000;
    end else begin
      if (wr && idx == 10'h080) gcon <= pwdata[7:0];
      if (wr && idx == 10'h081) bt1 <= pwdata[7:0];
      if (wr && idx == 10'h082) bt2 <= pwdata[7:0];
      if (wr && idx == 10'h083) bt3 <= pwdata[7:0];
      if (wr && idx == 10'h0b1) sel <= pwdata[5:4];
      if (wr && idx == 10'h0b3) reply_valid[sel] <= pwdata[5];
      if (psel && penable && !pwrite && idx == 10'h08a && prdata[1:0] == 2'h2) off_seen <= 1'b1;
      if (tx_err) txe_seen <= 1'b1;
      sp_cnt  <= sample_point ? 12'h000 : sp_cnt + 12'h001;
      sp_ok   <= (sample_point | sp_ok) & can_rx & !(wr && idx[9:2] == 8'h20);
      ovf_cnt <= (wr && idx == 10'h080 && !gcon[1]) ? 24'h00_0000 : ovf_cnt + 24'h00_0001;
      if (wr && idx == 10'h080 && pwdata[1] && !gcon[1]) ovf_ok <= 1'b1;
      else if (timer_overrun || (wr && idx == 10'h081)) ovf_ok <= 1'b0;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  AST_BUSOFF_QUIET: assert property (off_seen |-> !can_tx_oe)
    else $error("bus off node drives the bus");
  AST_BIT_PERIOD: assert property (sample_point && sp_ok |-> sp_cnt == sp_len - 12'h001)
    else $error("sample point spacing differs from programmed bit time");
  AST_OVF_ENABLED: assert property (timer_overrun |-> gcon[7])
    else $error("overrun pulse while overrun enable is clear");
  AST_TIMER_GATED: assert property (timer_overrun |-> gcon[1])
    else $error("timer wrapped while controller disabled");
  AST_WRAP_TIME: assert property (timer_overrun && ovf_ok |-> ovf_cnt + 24'h00_0002 >= ovf_len && ovf_cnt <= ovf_len + 24'h00_0002)
    else $error("timer wrap not 65536 quanta after enable");
  AST_OVF_PULSE: assert property ($rose(timer_overrun) |=> !timer_overrun)
    else $error("overrun is not a single pulse");
  AST_TTC_NO_RETRY: assert property (gcon[5] |-> !retransmit_ok)
    else $error("retransmission allowed in time triggered mode");
  AST_REPLY_GATE: assert property (remote_rx && !reply_valid[ev_obj] |-> !reply_go)
    else $error("remote reply without reply valid");
  AST_TEC_SEPARATE: assert property (psel && penable && !pwrite && idx == 10'h08b && !txe_seen |-> prdata[7:0] == 8'h00)
    else $error("transmit counter moved without transmit errors");
  // main scenarios reached
  cover property (off_seen);
  cover property (sample_point && sp_ok);
  cover property (timer_overrun && ovf_ok);
endmodule // cbt_checker

bind cbt_core cbt_checker u_chk (
  .clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .can_rx(can_rx), .can_tx_oe(can_tx_oe),
  .tx_err(tx_err), .remote_rx(remote_rx), .ev_obj(ev_obj), .sample_point(sample_point),
  .retransmit_ok(retransmit_ok), .reply_go(reply_go), .timer_overrun(timer_overrun)
);

// >>> dv/cbt_bus_node.sv
// Purpose: other nodes on the shared can bus
// Assumes: dominant is 0; an undriven line sits recessive
// Notes:   the bench holds node_dom low, so dominant bits come only from the dut
`timescale 1ns/1ns
module cbt_bus_node (
  // drivers
  input  wire dut_oe,
  input  wire node_dom,
  // resolved level
  output wire can_rx
);
  // wired-and: any dominant driver wins, the pull-up gives recessive
  assign can_rx = !(dut_oe | node_dom);
endmodule // cbt_bus_node

// >>> dv/can_bit_timing_and_message_objects_bench.sv
// Purpose: self-checking bench for cbt_core over apb
// Assumes: prescaler 0, so one quantum is one clock
// Notes:   timer wrap waits 65536 clocks, the longest part of the run
`timescale 1ns/1ns
module can_bit_timing_and_message_objects_bench;
  logic        clk, rst_b, psel, penable, pwrite, tx_bit, err_frame_req, node_dom;
  logic        pready, pslverr, can_rx, can_tx_oe, sample_point, send_active_err;
  logic        retransmit_ok, tx_allowed, reply_go, timer_overrun;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [6:0]  evs;
  logic [1:0]  ev_obj;
  logic [3:0]  rx_dlc;
  logic [4:0]  snap;
  logic [7:0]  rdv, n;
  logic [15:0] va, vb;
  int          mismatches, tests_run, cycles, i;
  localparam logic [6:0] SOF = 7'h40, EOF = 7'h20, RECEIVE_OK_FLAG = 7'h10, TRANSMIT_OK_FLAG = 7'h08;
  localparam logic [6:0] REM = 7'h04, TXE = 7'h02, RXE = 7'h01;
  cbt_bus_node u_node (.dut_oe(can_tx_oe), .node_dom(node_dom), .can_rx(can_rx));
  cbt_core u_dut (
    .clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .can_rx(can_rx), .can_tx(), .can_tx_oe(can_tx_oe),
    .frame_sof(evs[6]), .frame_eof(evs[5]), .rx_ok(evs[4]), .tx_ok(evs[3]),
    .remote_rx(evs[2]), .tx_err(evs[1]), .rx_err(evs[0]), .ev_obj(ev_obj), .rx_dlc(rx_dlc),
    .tx_bit(tx_bit), .err_frame_req(err_frame_req), .sample_point(sample_point),
    .sampled_bit(), .send_active_err(send_active_err), .retransmit_ok(retransmit_ok),
    .tx_allowed(tx_allowed), .reply_go(reply_go), .timer_overrun(timer_overrun)
  );
  always #4 clk = ~clk;
  // hang guard: the run needs about 65600 cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 90000) begin
      mismatches = mismatches + 1;
      tally_and_finish;
    end
  end
  task tally_and_finish;
    begin
      if (mismatches == 0 && tests_run > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
    end
  endtask
  task check(input logic [15:0] seen, input logic [15:0] exp);
    begin
      tests_run = tests_run + 1;
      if (seen !== exp) begin
        mismatches = mismatches + 1;
        $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
      end
    end
  endtask
  // one apb transfer, held until pready is seen high at an edge
  task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    begin
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= {2'b00, a, 2'b00};
      pwdata  <= {24'h00_0000, d};
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      rdv     = prdata[7:0];
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
    end
  endtask
  task rdc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    begin
      apb(1'b0, a, 8'h00);
      check({8'h00, rdv & m}, {8'h00, e});
    end
  endtask
  task rd16(input logic [7:0] a, output logic [15:0] v);
    begin
      apb(1'b0, a, 8'h00);
      v[7:0] = rdv;
      apb(1'b0, a + 8'h01, 8'h00);
      v[15:8] = rdv;
    end
  endtask
  // status levels sampled mid-cycle at the falling edge, away from the rising edge
  task look;
    begin
      @(negedge clk);
      snap = {send_active_err, can_tx_oe, tx_allowed, reply_go, retransmit_ok};
      @(posedge clk);
    end
  endtask
  task ev(input logic [6:0] m, input logic [1:0] o);
    begin
      evs    <= m;
      ev_obj <= o;
      look;
      evs    <= 7'h00;
      @(posedge clk);
    end
  endtask
  initial begin
    {clk, rst_b, psel, penable, pwrite, node_dom, err_frame_req} = 7'h00;
    {tx_bit, paddr, pwdata, evs, ev_obj, rx_dlc} = {1'b1, 53'h0, 4'h5};
    {mismatches, tests_run, cycles} = 0;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    rdc(8'hb1, 8'hff, 8'h00);
    rdc(8'h8a, 8'hff, 8'h00);
    rdc(8'h00, 8'hff, 8'h00);
    // bit time 1+3+4+3 = 11 quanta, jump width 2
    apb(1'b1, 8'h81, 8'h00);
    apb(1'b1, 8'h82, 8'h12);
    apb(1'b1, 8'h83, 8'h23);
    apb(1'b1, 8'h80, 8'h82);
    @(negedge clk);
    while (sample_point !== 1'b1) @(negedge clk);
    n = 8'h00;
    do begin
      @(negedge clk);
      n = n + 8'h01;
    end while (sample_point !== 1'b1 && n < 8'hff);
    @(posedge clk);
    check({8'h00, n}, 16'h000b);
    // four bytes into object 1 with auto-advance, then object 2
    apb(1'b1, 8'hb1, 8'h10);
    for (i = 0; i < 4; i++) apb(1'b1, 8'hb2, 8'ha0 + i[7:0]);
    rdc(8'hb1, 8'hff, 8'h14);
    apb(1'b1, 8'hb1, 8'h20);
    apb(1'b1, 8'hb2, 8'h55);
    apb(1'b1, 8'hb1, 8'h1a);
    for (i = 0; i < 2; i++) rdc(8'hb2, 8'hff, 8'ha2);
    rdc(8'hb1, 8'hff, 8'h1a);
    apb(1'b1, 8'hb1, 8'h10);
    for (i = 0; i < 4; i++) rdc(8'hb2, 8'hff, 8'ha0 + i[7:0]);
    // every configuration code, object n gets code n
    for (i = 0; i < 4; i++) begin
      apb(1'b1, 8'hb1, {2'b00, i[1:0], 4'h0});
      apb(1'b1, 8'hb3, {i[1:0], 6'h00});
    end
    rdc(8'h8d, 8'h0f, 8'h0e);
    ev(REM, 2'h2);
    check({15'h0000, snap[1]}, 16'h0000);
    apb(1'b1, 8'hb1, 8'h30);
    apb(1'b1, 8'hb3, 8'he0);
    ev(REM, 2'h3);
    check({15'h0000, snap[1]}, 16'h0001);
    // object 1 expects eight bytes, five arrive
    apb(1'b1, 8'hb1, 8'h10);
    apb(1'b1, 8'hb3, 8'h88);
    ev(RECEIVE_OK_FLAG, 2'h1);
    rdc(8'hb3, 8'h0f, 8'h05);
    rdc(8'h8e, 8'ha0, 8'ha0);
    rd16(8'h88, va);
    check({15'h0000, va != 16'h0000}, 16'h0001);
    // capture at start of frame, end of frame ignored until selected
    apb(1'b1, 8'h80, 8'ha2);
    look;
    check({15'h0000, snap[0]}, 16'h0000);
    ev(SOF, 2'h0);
    rd16(8'h86, va);
    ev(EOF, 2'h0);
    rd16(8'h86, vb);
    check(vb, va);
    apb(1'b1, 8'h80, 8'hb2);
    ev(EOF, 2'h0);
    rd16(8'h86, vb);
    check({15'h0000, vb != va}, 16'h0001);
    apb(1'b1, 8'h80, 8'h82);
    {tx_bit, err_frame_req} <= 2'b01;
    look;
    check({14'h0000, snap[4:3]}, 16'h0003);
    for (i = 0; i < 3; i++) ev(RXE, 2'h0);
    rdc(8'h8c, 8'hff, 8'h03);
    rdc(8'h8b, 8'hff, 8'h00);
    for (i = 0; i < 17; i++) ev(TXE, 2'h0);
    rdc(8'h8b, 8'hff, 8'h88);
    rdc(8'h8a, 8'h03, 8'h01);
    look;
    check({15'h0000, snap[4]}, 16'h0000);
    ev(TRANSMIT_OK_FLAG, 2'h0);
    look;
    check({15'h0000, snap[2]}, 16'h0000);
    for (i = 0; i < 16; i++) ev(TXE, 2'h0);
    rdc(8'h8a, 8'h03, 8'h02);
    look;
    check({15'h0000, snap[3]}, 16'h0000);
    for (i = 0; i < 70000 && timer_overrun !== 1'b1; i++) @(negedge clk);
    check({15'h0000, timer_overrun}, 16'h0001);
    @(posedge clk);
    tally_and_finish;
  end
endmodule // can_bit_timing_and_message_objects_bench
